// [verilog/ssmp_pkg.sv]
// Purpose: Shared constants and types of the serial slave memory port
// Assumes: 32-bit APB register bus, 8-bit data memory bus with 16-bit address
// Notes:   Offsets are byte addresses on the APB bus
package ssmp_pkg;

    localparam int          APB_AW         = 12;
    localparam int          APB_DW         = 32;
    localparam int          MEM_AW         = 16;
    localparam int          MEM_DW         = 8;

    // Register offsets
    localparam logic [11:0] REG_CTRL_OFS   = 12'h000;
    localparam logic [11:0] REG_STATUS_OFS = 12'h004;
    localparam logic [11:0] REG_CMD_OFS    = 12'h008;
    localparam logic [11:0] REG_ADDR_OFS   = 12'h00c;

    // Field positions
    localparam int          CTRL_EN_BIT    = 0;
    localparam int          CTRL_QUIET_BIT = 1;
    localparam int          STAT_FLAG_BIT  = 0;
    localparam int          STAT_BUSY_BIT  = 1;

    // Reset values
    localparam logic        EN_RST         = 1'b0;
    localparam logic        QUIET_RST      = 1'b0;
    localparam logic        FLAG_RST       = 1'b0;
    localparam logic [7:0]  CMD_RST        = 8'h00;
    localparam logic [15:0] ADDR_RST       = 16'h0000;

    // Command decode, top two bits
    localparam logic [1:0]  CMD_READ       = 2'b11;
    localparam logic [1:0]  CMD_WRITE      = 2'b10;

    // Serial framing
    localparam logic [2:0]  BIT_FIRST      = 3'h0;
    localparam logic [2:0]  BIT_LAST       = 3'h7;
    localparam logic [2:0]  BIT_STEP       = 3'h1;
    localparam logic [15:0] ADDR_STEP      = 16'h0001;

    // Host gap before first read data clock, and its count at 125 MHz
    localparam int          CLK_PERIOD_NS  = 8;
    localparam int          READ_GAP_NS    = 1000;
    localparam int          READ_GAP_CYC   = (READ_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    typedef enum logic [4:0]
    {
        PH_IDLE    = 5'b00001,
        PH_CMD     = 5'b00010,
        PH_ADDR_HI = 5'b00100,
        PH_ADDR_LO = 5'b01000,
        PH_DATA    = 5'b10000
    } ssmp_phase_t;

endpackage

// [verilog/ssmp_sync.sv]
// Purpose: Two-flop synchroniser for the host pins
// Assumes: Inputs are asynchronous to mclk_i
// Notes:   First stage feeds only the second stage
`timescale 1ns/1ns
module ssmp_sync
#(
    parameter int               WIDTH     = 3,
    parameter logic [WIDTH-1:0] RESET_VAL = '0
)
(
    input  wire logic             mclk_i,
    input  wire logic             resetn_i,
    input  wire logic [WIDTH-1:0] async_i,
    output logic      [WIDTH-1:0] sync_o
);

    logic [WIDTH-1:0] meta_reg;

    always_ff @(posedge mclk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            meta_reg <= RESET_VAL;
            sync_o   <= RESET_VAL;
        end
        else
        begin
            meta_reg <= async_i;
            sync_o   <= meta_reg;
        end
    end

endmodule

// [verilog/ssmp_port.sv]
// Purpose: Serial slave port giving a host byte access to the data memory space
// Assumes: Host pins asynchronous to mclk_i; memory bus answers with mem_ack_i
// Notes:   APB slave holds control, status and capture registers
//
// Contract
// - Select high holds the serial port in reset, dropping partial transfers.
// - Deselected: serial output floats; clock and data pins are ignored.
// - After select falls, shifting starts on the first rising serial clock.
// - Host raises select to end; device concludes and raises its interrupt.
// - A command-only transaction completes normally on deselect.
// - Read: command, 16-bit address, then device returns 8-bit data.
// - Write: command, 16-bit address, then data bytes stored at that address.
// - Transfer address advances by one after every data byte.
// - Port pins are shared pads and default to LCD driving after reset.
// - The 16-bit address spans the whole external data memory space only.
// - Host writes normally raise an MPU interrupt; quiet insertion is possible.
// - Last command and address are captured in readable registers.
// - Captured address keeps the host value, not the incremented one.
// - Done flag is set by hardware, cleared only by writing zero.
// - Done flag is set after every transaction, whatever the command.
// - Top bits 11 read, 10 write; top bit 0 means no access.
//
// The APB register port and the register addresses were decided locally.
`timescale 1ns/1ns
module ssmp_port
    import ssmp_pkg::*;
(
    input  wire logic              mclk_i,
    input  wire logic              resetn_i,
    // APB slave
    input  wire logic              psel_i,
    input  wire logic              penable_i,
    input  wire logic              pwrite_i,
    input  wire logic [APB_AW-1:0] paddr_i,
    input  wire logic [APB_DW-1:0] pwdata_i,
    output logic                   pready_o,
    output logic      [APB_DW-1:0] prdata_o,
    output logic                   pslverr_o,
    // Host pins
    input  wire logic              host_select_n_i,
    input  wire logic              host_clk_i,
    input  wire logic              host_serial_in_i,
    output logic                   host_serial_out_o,
    output logic                   host_serial_out_oe_o,
    output logic                   pad_serial_sel_o,
    // Data memory bus
    output logic                   mem_req_o,
    output logic                   mem_we_o,
    output logic      [MEM_AW-1:0] mem_addr_o,
    output logic      [MEM_DW-1:0] mem_wdata_o,
    input  wire logic [MEM_DW-1:0] mem_rdata_i,
    input  wire logic              mem_ack_i,
    // Events to the MPU
    output logic                   port_irq_o,
    output logic                   host_write_irq_o
);

    logic [2:0]        sync_q;
    logic              sel_n_s, sclk_s, sdi_s, sclk_d_reg, sclk_rise, sclk_fall;
    logic              en_reg, quiet_reg, host_done_flag_reg, active_reg, port_on, end_evt;
    ssmp_phase_t       phase_reg;
    logic [2:0]        bit_cnt_reg;
    logic [7:0]        rx_sh_reg, rx_byte, host_cmd_cap_reg, addr_hi_reg, tx_reg;
    logic              byte_done, is_read, is_write, start_rd, start_wr, rd_pending_reg;
    logic [MEM_AW-1:0] host_addr_cap_reg, xfer_addr_reg, rd_addr_next;
    logic              apb_acc, apb_commit, wr_ctrl, wr_status;
    logic [APB_DW-1:0] rd_word;

    default clocking dc @(posedge mclk_i); endclocking
    default disable iff (!resetn_i);

    function automatic logic reg_hit(input logic [APB_AW-1:0] a);
        reg_hit = (a == REG_CTRL_OFS) || (a == REG_STATUS_OFS)
               || (a == REG_CMD_OFS) || (a == REG_ADDR_OFS);
    endfunction
    // Pin synchroniser, select idles high
    ssmp_sync #(.WIDTH (3), .RESET_VAL (3'h4)) u_sync
    (
        .mclk_i   (mclk_i),
        .resetn_i (resetn_i),
        .async_i  ({host_select_n_i, host_clk_i, host_serial_in_i}),
        .sync_o   (sync_q)
    );
    assign sel_n_s   = sync_q[2];
    assign sclk_s    = sync_q[1];
    assign sdi_s     = sync_q[0];
    assign sclk_rise = sclk_s & ~sclk_d_reg;
    assign sclk_fall = ~sclk_s & sclk_d_reg;
    assign port_on   = ~sel_n_s & en_reg;
    assign end_evt   = sel_n_s & active_reg & en_reg;
    assign rx_byte   = {rx_sh_reg[6:0], sdi_s};
    assign byte_done = port_on & sclk_rise & (bit_cnt_reg == BIT_LAST);
    assign is_read   = (host_cmd_cap_reg[7:6] == CMD_READ);
    assign is_write  = (host_cmd_cap_reg[7:6] == CMD_WRITE);
    assign start_rd  = byte_done & is_read
                     & ((phase_reg == PH_ADDR_LO) || (phase_reg == PH_DATA));
    assign start_wr  = byte_done & is_write & (phase_reg == PH_DATA);
    assign rd_addr_next = (phase_reg == PH_ADDR_LO) ? {addr_hi_reg, rx_byte}
                                                    : xfer_addr_reg + ADDR_STEP;
    // Serial clock edge detect
    always_ff @(posedge mclk_i or negedge resetn_i)
    begin
        if (!resetn_i)
            sclk_d_reg <= 1'b0;
        else
            sclk_d_reg <= sclk_s;
    end
    // Transaction tracking
    always_ff @(posedge mclk_i or negedge resetn_i)
    begin
        if (!resetn_i)
            active_reg <= 1'b0;
        else
            active_reg <= port_on;
    end
    // Framing state
    always_ff @(posedge mclk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            phase_reg   <= PH_IDLE;
            bit_cnt_reg <= BIT_FIRST;
            rx_sh_reg   <= CMD_RST;
        end
        else if (!port_on)
        begin
            phase_reg   <= PH_IDLE;
            bit_cnt_reg <= BIT_FIRST;
            rx_sh_reg   <= CMD_RST;
        end
        else if (phase_reg == PH_IDLE)
            phase_reg <= PH_CMD;
        else if (sclk_rise)
        begin
            rx_sh_reg   <= rx_byte;
            bit_cnt_reg <= bit_cnt_reg + BIT_STEP;
            if (bit_cnt_reg == BIT_LAST)
            begin
                case (phase_reg)
                    PH_CMD:     phase_reg <= PH_ADDR_HI;
                    PH_ADDR_HI: phase_reg <= PH_ADDR_LO;
                    PH_ADDR_LO: phase_reg <= PH_DATA;
                    PH_DATA:    phase_reg <= PH_DATA;
                    default:    phase_reg <= PH_IDLE;
                endcase
            end
        end
    end
    // Command and address capture
    always_ff @(posedge mclk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            host_cmd_cap_reg  <= CMD_RST;
            addr_hi_reg       <= CMD_RST;
            host_addr_cap_reg <= ADDR_RST;
        end
        else if (byte_done)
        begin
            if (phase_reg == PH_CMD)
                host_cmd_cap_reg <= rx_byte;
            if (phase_reg == PH_ADDR_HI)
                addr_hi_reg <= rx_byte;
            if (phase_reg == PH_ADDR_LO)
                host_addr_cap_reg <= {addr_hi_reg, rx_byte};
        end
    end
    // Internal transfer address
    always_ff @(posedge mclk_i or negedge resetn_i)
    begin
        if (!resetn_i)
            xfer_addr_reg <= ADDR_RST;
        else if (byte_done && (phase_reg == PH_ADDR_LO))
            xfer_addr_reg <= {addr_hi_reg, rx_byte};
        else if (byte_done && (phase_reg == PH_DATA))
            xfer_addr_reg <= xfer_addr_reg + ADDR_STEP;
    end
    // Memory bus cycle
    always_ff @(posedge mclk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            mem_req_o   <= 1'b0;
            mem_we_o    <= 1'b0;
            mem_addr_o  <= ADDR_RST;
            mem_wdata_o <= CMD_RST;
        end
        else if (start_rd || start_wr)
        begin
            mem_req_o   <= 1'b1;
            mem_we_o    <= start_wr;
            mem_addr_o  <= start_wr ? xfer_addr_reg : rd_addr_next;
            mem_wdata_o <= rx_byte;
        end
        else if (mem_req_o && mem_ack_i)
            mem_req_o <= 1'b0;
    end
    // Read prefetch bookkeeping
    always_ff @(posedge mclk_i or negedge resetn_i)
    begin
        if (!resetn_i)
            rd_pending_reg <= 1'b0;
        else if (!port_on)
            rd_pending_reg <= 1'b0;
        else if (start_rd)
            rd_pending_reg <= 1'b1;
        else if (mem_req_o && mem_ack_i)
            rd_pending_reg <= 1'b0;
    end
    // Serial output
    always_ff @(posedge mclk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            tx_reg               <= CMD_RST;
            host_serial_out_o    <= 1'b0;
            host_serial_out_oe_o <= 1'b0;
        end
        else if (!port_on)
        begin
            tx_reg               <= CMD_RST;
            host_serial_out_o    <= 1'b0;
            host_serial_out_oe_o <= 1'b0;
        end
        else
        begin
            host_serial_out_oe_o <= is_read && (phase_reg == PH_DATA);
            if (rd_pending_reg && mem_req_o && mem_ack_i)
            begin
                tx_reg            <= mem_rdata_i;
                host_serial_out_o <= mem_rdata_i[7];
            end
            else if (sclk_fall && (phase_reg == PH_DATA) && (bit_cnt_reg != BIT_FIRST))
                host_serial_out_o <= tx_reg[BIT_LAST - bit_cnt_reg];
        end
    end
    // Write notification
    always_ff @(posedge mclk_i or negedge resetn_i)
    begin
        if (!resetn_i)
            host_write_irq_o <= 1'b0;
        else
            host_write_irq_o <= start_wr & ~quiet_reg;
    end
    // Pad function select
    always_ff @(posedge mclk_i or negedge resetn_i)
    begin
        if (!resetn_i)
            pad_serial_sel_o <= EN_RST;
        else
            pad_serial_sel_o <= en_reg;
    end
    // APB access
    assign apb_acc    = psel_i & penable_i;
    assign apb_commit = apb_acc & pready_o;
    assign wr_ctrl    = apb_commit & pwrite_i & (paddr_i == REG_CTRL_OFS);
    assign wr_status  = apb_commit & pwrite_i & (paddr_i == REG_STATUS_OFS);

    always_comb
    begin
        rd_word = '0;
        case (paddr_i)
            REG_CTRL_OFS:
            begin
                rd_word[CTRL_EN_BIT]    = en_reg;
                rd_word[CTRL_QUIET_BIT] = quiet_reg;
            end
            REG_STATUS_OFS:
            begin
                rd_word[STAT_FLAG_BIT] = host_done_flag_reg;
                rd_word[STAT_BUSY_BIT] = active_reg;
            end
            REG_CMD_OFS:  rd_word[MEM_DW-1:0] = host_cmd_cap_reg;
            REG_ADDR_OFS: rd_word[MEM_AW-1:0] = host_addr_cap_reg;
            default:      rd_word = '0;
        endcase
    end
    always_ff @(posedge mclk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            pready_o  <= 1'b0;
            prdata_o  <= '0;
            pslverr_o <= 1'b0;
        end
        else
        begin
            pready_o <= apb_acc & ~pready_o;
            if (apb_acc && !pready_o)
            begin
                prdata_o  <= rd_word;
                pslverr_o <= ~reg_hit(paddr_i);
            end
        end
    end
    // Control register
    always_ff @(posedge mclk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            en_reg    <= EN_RST;
            quiet_reg <= QUIET_RST;
        end
        else if (wr_ctrl)
        begin
            en_reg    <= pwdata_i[CTRL_EN_BIT];
            quiet_reg <= pwdata_i[CTRL_QUIET_BIT];
        end
    end
    // Done flag, set wins over clear
    always_ff @(posedge mclk_i or negedge resetn_i)
    begin
        if (!resetn_i)
            host_done_flag_reg <= FLAG_RST;
        else if (end_evt)
            host_done_flag_reg <= 1'b1;
        else if (wr_status && !pwdata_i[STAT_FLAG_BIT])
            host_done_flag_reg <= 1'b0;
    end
    always_ff @(posedge mclk_i or negedge resetn_i)
    begin
        if (!resetn_i)
            port_irq_o <= FLAG_RST;
        else
            port_irq_o <= host_done_flag_reg;
    end
    // Checks
    a_oe_off_deselected: assert property (sel_n_s |=> !host_serial_out_oe_o)
        else $error("serial output driven while deselected");
    a_reset_while_high: assert property (
        sel_n_s |=> (phase_reg == PH_IDLE) && (bit_cnt_reg == BIT_FIRST))
        else $error("port not held in reset while deselected");
    a_flag_at_end: assert property (end_evt |=> host_done_flag_reg ##1 port_irq_o)
        else $error("done flag or interrupt missing after deselect");
    a_flag_sticky: assert property (
        host_done_flag_reg && !(wr_status && !pwdata_i[STAT_FLAG_BIT]) |=> host_done_flag_reg)
        else $error("done flag cleared without a zero write");
    a_refuse_disabled: assert property (
        !en_reg |=> (phase_reg == PH_IDLE) && !$rose(mem_req_o))
        else $error("port active while disabled");
    a_addr_cap_holds: assert property (
        (phase_reg == PH_DATA) |=> $stable(host_addr_cap_reg))
        else $error("captured address changed during data bytes");
    a_addr_increments: assert property (
        byte_done && (phase_reg == PH_DATA) |=> xfer_addr_reg == $past(xfer_addr_reg) + ADDR_STEP)
        else $error("transfer address did not advance by one");
    a_cmd_captured: assert property (
        byte_done && (phase_reg == PH_CMD) |=> host_cmd_cap_reg == $past(rx_byte))
        else $error("command byte not captured");
    a_access_needs_cmd: assert property (
        $rose(mem_req_o) |-> host_cmd_cap_reg[7] && (mem_we_o == !host_cmd_cap_reg[6]))
        else $error("memory access for a non access command");
    a_quiet_insert: assert property (
        start_wr |=> (host_write_irq_o == !$past(quiet_reg)))
        else $error("write notification does not follow quiet bit");
    a_write_stores: assert property (
        start_wr |=> mem_req_o && mem_we_o && (mem_wdata_o == $past(rx_byte))
                     && (mem_addr_o == $past(xfer_addr_reg)))
        else $error("write byte not presented to memory");
    a_pads_follow_en: assert property (!en_reg |=> !pad_serial_sel_o)
        else $error("pads switched to serial port while disabled");

endmodule

// [verification/ssmp_host_model.sv]
// Purpose: Behavioural host that drives the serial port pins
// Assumes: 64 ns serial clock, idle low, phase unrelated to mclk_i
// Notes:   Data pin shows the inverse of its last value when not in use
`timescale 1ns/1ns
module ssmp_host_model
(
    output logic      sel_n_o,
    output logic      sclk_o,
    output logic      sdi_o,
    input  wire logic sdo_i,
    input  wire logic sdo_oe_i
);
    initial
    begin
        sel_n_o = 1'b1;
        sclk_o  = 1'b0;
        sdi_o   = 1'b0;
    end

    // Select low, then let the synchroniser see it
    task automatic start();
        #7 sel_n_o = 1'b0;
        #100;
    endtask

    // Raise select to close the frame
    task automatic stop();
        #40 sel_n_o = 1'b1;
        sdi_o = ~sdi_o;
        #300;
    endtask

    // Pause before first read data clock
    task automatic gap();
        #1100;
    endtask

    // Shift nb bits MSB first; data set while clock low, sampled on rise
    task automatic xbits(input logic [7:0] tx, input int nb, output logic [7:0] rx);
        rx = 8'h00;
        for (int i = 7; i > 7 - nb; i--)
        begin
            sdi_o = tx[i];
            #32 sclk_o = 1'b1;
            rx[i] = sdo_oe_i ? sdo_i : 1'bx;
            #32 sclk_o = 1'b0;
        end
        sdi_o = ~sdi_o;
    endtask
endmodule

// [verification/serial_slave_memory_port_test.sv]
// Purpose: Self-checking bench of the serial slave memory port
// Assumes: APB master, host model and a memory with random ack delay
// Notes:   Memory writes and APB reads are checked against queued notes
`timescale 1ns/1ns
module serial_slave_memory_port_test;
    import ssmp_pkg::*;
    logic              mclk_i, resetn_i, psel_i, penable_i, pwrite_i;
    logic [APB_AW-1:0] paddr_i;
    logic [APB_DW-1:0] pwdata_i, prdata_o;
    logic              pready_o, pslverr_o, sel_n, sclk, sdi, sdo, sdo_oe, pad_sel;
    logic              mem_req_o, mem_we_o, mem_ack_i, port_irq_o, host_write_irq_o;
    logic [MEM_AW-1:0] mem_addr_o;
    logic [MEM_DW-1:0] mem_wdata_o, mem_rdata_i;
    logic [7:0]        mem [65536];
    logic [7:0]        dbuf [4];
    logic [32:0]       exp_rd [$];
    logic [23:0]       exp_mw [$];
    logic [15:0]       a;
    logic [1:0]        wcnt;
    logic [7:0]        rx;
    logic              en;
    int                err_count, n_tests, irq_n;

    ssmp_port DUT (.mclk_i(mclk_i), .resetn_i(resetn_i), .psel_i(psel_i),
        .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
        .pwdata_i(pwdata_i), .pready_o(pready_o), .prdata_o(prdata_o),
        .pslverr_o(pslverr_o), .host_select_n_i(sel_n), .host_clk_i(sclk),
        .host_serial_in_i(sdi), .host_serial_out_o(sdo), .host_serial_out_oe_o(sdo_oe),
        .pad_serial_sel_o(pad_sel), .mem_req_o(mem_req_o), .mem_we_o(mem_we_o),
        .mem_addr_o(mem_addr_o), .mem_wdata_o(mem_wdata_o), .mem_rdata_i(mem_rdata_i),
        .mem_ack_i(mem_ack_i), .port_irq_o(port_irq_o),
        .host_write_irq_o(host_write_irq_o));

    ssmp_host_model host (.sel_n_o(sel_n), .sclk_o(sclk), .sdi_o(sdi), .sdo_i(sdo),
        .sdo_oe_i(sdo_oe));

    initial
    begin
        mclk_i = 1'b0;
        forever #4 mclk_i = ~mclk_i;
    end

    task automatic chk_apb(input logic [32:0] got, input logic [32:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            err_count++;
            $display("[ERR] %0t register read %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chk_mem(input logic [23:0] got, input logic [23:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            err_count++;
            $display("[ERR] %0t memory write %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            err_count++;
            $display("[ERR] %0t pin value %h expected %h", $time, got, exp);
        end
    endtask

    task automatic give_verdict();
        if (err_count == 0 && n_tests > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    // Memory with random ack delay; write notes are checked at the ack
    always @(posedge mclk_i)
    begin
        mem_ack_i <= 1'b0;
        if (mem_ack_i && mem_we_o)
            chk_mem({mem_addr_o, mem_wdata_o}, exp_mw.size() ? exp_mw.pop_front() : 'x);
        if (mem_req_o === 1'b1 && !mem_ack_i)
        begin
            if (wcnt == 2'd0)
            begin
                mem_ack_i   <= 1'b1;
                mem_rdata_i <= mem[mem_addr_o];
                if (mem_we_o)
                    mem[mem_addr_o] <= mem_wdata_o;
                wcnt <= 2'($urandom_range(3, 0));
            end
            else
                wcnt <= wcnt - 2'd1;
        end
    end

    // Read notes are checked at the edge that completes the access
    always @(posedge mclk_i)
    begin
        if (psel_i && penable_i && pready_o === 1'b1 && !pwrite_i)
            chk_apb({pslverr_o, prdata_o}, exp_rd.pop_front());
        if (host_write_irq_o === 1'b1)
            irq_n <= irq_n + 1;
    end

    task automatic apb(input logic wr, input logic [11:0] ad, input logic [31:0] d,
                       input logic [32:0] ex);
        int t;
        @(posedge mclk_i);
        if (!wr)
            exp_rd.push_back(ex);
        psel_i   <= 1'b1;
        pwrite_i <= wr;
        paddr_i  <= ad;
        pwdata_i <= d;
        @(posedge mclk_i);
        penable_i <= 1'b1;
        t = 0;
        do
        begin
            @(posedge mclk_i);
            t++;
        end
        while (pready_o !== 1'b1 && t < 50);
        if (pready_o !== 1'b1)
            err_count++;
        psel_i    <= 1'b0;
        penable_i <= 1'b0;
    endtask

    // Check done flag, then clear it by writing zero
    task automatic flag_chk(input logic b);
        apb(1'b0, REG_STATUS_OFS, 32'h0, {32'h0, b});
        apb(1'b1, REG_STATUS_OFS, 32'h0, 33'h0);
    endtask

    // n < 0: command only; reads compare against dbuf
    task automatic frame(input logic [7:0] cmd, input int n, input logic [15:0] ad);
        host.start();
        host.xbits(cmd, 8, rx);
        if (n >= 0)
        begin
            host.xbits(ad[15:8], 8, rx);
            host.xbits(ad[7:0], 8, rx);
        end
        if (cmd[7:6] == CMD_READ && n > 0)
            host.gap();
        for (int i = 0; i < n; i++)
        begin
            if (cmd[7:6] == CMD_READ)
            begin
                host.xbits(8'h00, 8, rx);
                chk_byte(rx, dbuf[i]);
            end
            else
            begin
                if (cmd[7:6] == CMD_WRITE && en)
                    exp_mw.push_back({16'(ad + i), dbuf[i]});
                host.xbits(dbuf[i], 8, rx);
            end
        end
        host.stop();
        chk_byte({7'h0, sdo_oe}, 8'h00);
    endtask

    initial
    begin
        void'($urandom(32'hf2acab80));
        foreach (mem[i])
            mem[i] = 8'(i);
        {resetn_i, psel_i, penable_i, pwrite_i, mem_ack_i, en, wcnt} = '0;
        {paddr_i, pwdata_i, mem_rdata_i, err_count, n_tests, irq_n} = '0;
        repeat (2) @(posedge mclk_i);
        resetn_i <= 1'b1;
        repeat (3) @(posedge mclk_i);
        foreach (dbuf[i])
            dbuf[i] = 8'($urandom);
        for (int k = 0; k < 4; k++)
            apb(1'b0, 12'(4 * k), 32'h0, 33'h0);
        apb(1'b0, 12'h010, 32'h0, {1'b1, 32'h0});
        chk_byte({7'h0, pad_sel}, 8'h00);
        frame(8'h80, 1, 16'h1234);
        flag_chk(1'b0);
        apb(1'b1, REG_CTRL_OFS, 32'h1, 33'h0);
        repeat (3) @(posedge mclk_i);
        chk_byte({7'h0, pad_sel}, 8'h01);
        en = 1'b1;
        a  = 16'($urandom_range(16'hff00, 0));
        frame(8'h80 | 8'($urandom_range(63, 0)), 3, a);
        chk_byte(8'(irq_n), 8'd3);
        chk_byte({7'h0, port_irq_o}, 8'h01);
        apb(1'b0, REG_ADDR_OFS, 32'h0, {17'h0, a});
        apb(1'b1, REG_STATUS_OFS, 32'h1, 33'h0);
        flag_chk(1'b1);
        flag_chk(1'b0);
        frame(8'hc5, 3, a);
        flag_chk(1'b1);
        apb(1'b1, REG_CTRL_OFS, 32'h3, 33'h0);
        irq_n = 0;
        dbuf[0] = 8'($urandom);
        frame(8'h81, 1, a + 16'h0010);
        chk_byte(8'(irq_n), 8'd0);
        frame(8'h3f, -1, 16'h0);
        flag_chk(1'b1);
        apb(1'b0, REG_CMD_OFS, 32'h0, 33'h3f);
        frame(8'h40, 2, a);
        flag_chk(1'b1);
        host.start();
        apb(1'b0, REG_STATUS_OFS, 32'h0, 33'h2);
        host.xbits(8'h80, 5, rx);
        host.stop();
        flag_chk(1'b1);
        frame(8'h80, 1, a + 16'h0020);
        apb(1'b0, REG_ADDR_OFS, 32'h0, {17'h0, 16'(a + 16'h0020)});
        chk_byte(8'(exp_mw.size()), 8'h00);
        give_verdict();
    end

    initial
    begin
        #500000;
        err_count++;
        give_verdict();
    end
endmodule
